// >>> serial_port_pkg.sv
// constants, types and register layout of the four-mode serial port
// assumes one cpu clock domain and a plain strobe register port
package serial_port_pkg;

  localparam int PW = 17;

  localparam logic [7:0] ADDR_CONFIG  = 8'h98;
  localparam logic [7:0] ADDR_DATA    = 8'h99;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  localparam logic [PW-1:0] DIV_SHIFT      = 17'h0000C;
  localparam logic [PW-1:0] DIV_FIXED_SLOW = 17'h00040;
  localparam logic [PW-1:0] DIV_FIXED_FAST = 17'h00020;
  localparam logic [PW-1:0] PERIOD_MIN     = 17'h00001;

  localparam logic [3:0] BITS_SHIFT  = 4'h8;
  localparam logic [3:0] BITS_ASYNC8 = 4'hA;
  localparam logic [3:0] BITS_NINE   = 4'hB;
  localparam logic [3:0] SAMPLES_8   = 4'h9;
  localparam logic [3:0] SAMPLES_9   = 4'hA;

  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_FIXED9 = 2'b10,
    MODE_VAR9   = 2'b11
  } mode_type;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } rx_state_type;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_config_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

endpackage

// >>> four_mode_serial_port.sv
// four-mode serial port: shift-register mode and three async modes
// assumes timer overflow inputs are one-cycle pulses on ref_clk and
// that the serial_in wire is open-drain, resolved outside
`timescale 1ns/1ps

module four_mode_serial_port (
  input  wire logic                        ref_clk,         // cpu clock
  input  wire logic                        resetn,          // sync reset
  input  wire serial_port_pkg::reg_req_type reg_req,        // reg access
  output logic [7:0]                       rd_data,         // read data
  input  wire logic                        baud_double_sel, // doubling
  input  wire logic                        tx_timer2_sel,   // t2 for tx
  input  wire logic                        rx_timer2_sel,   // t2 for rx
  input  wire logic                        timer1_ovf,      // t1 pulse
  input  wire logic                        timer2_ovf,      // t2 pulse
  input  wire logic                        slow_clock_mode, // slow mode
  output logic                             wake_pulse,      // wake req
  output logic                             serial_out_pin,  // tx / clk
  input  wire logic                        serial_in_i,     // rx level
  output logic                             serial_in_o,     // drive val
  output logic                             serial_in_oe     // drive en
);

  localparam int PW = serial_port_pkg::PW;

  serial_port_pkg::serial_config_type cfg_q;
  serial_port_pkg::mode_type          mode;
  serial_port_pkg::tx_state_type      tx_state_q;
  serial_port_pkg::rx_state_type      rx_state_q;

  logic [7:0]    rx_hold_q;
  logic [2:0]    rx_sync_q;
  logic [PW-1:0] ovf_cnt_q;
  logic [PW-1:0] ovf_period_q;
  logic [PW-1:0] bit_period;
  logic [PW-1:0] half;
  logic [10:0]   tx_shift_q;
  logic [3:0]    tx_bits_q;
  logic [PW-1:0] tx_cnt_q;
  logic [PW-1:0] rx_cnt_q;
  logic [3:0]    rx_bits_q;
  logic [9:0]    rx_shift_q;
  logic [9:0]    rx_word;
  logic [7:0]    rx_byte;
  logic          rx_s, rx_prev, nine, use_t2, ovf_sel, shift_clk;
  logic          wr_cfg, wr_dat, tx_go, tx_set, rx_go0, rx_go_async;
  logic          rx_sample, rx_last, rx_finish, rx_accept, rx_set;

  assign mode = serial_port_pkg::mode_type'({cfg_q.mode_select_high,
                                             cfg_q.mode_select_low});
  assign nine = cfg_q.mode_select_high;
  assign wr_cfg = reg_req.wr && reg_req.addr == serial_port_pkg::ADDR_CONFIG;
  assign wr_dat = reg_req.wr && reg_req.addr == serial_port_pkg::ADDR_DATA;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_sync_q <= 3'h7;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], serial_in_i};
    end
  end
  assign rx_s    = rx_sync_q[1];
  assign rx_prev = rx_sync_q[2];

  // in MODE_ASYNC8 and MODE_VAR9 one bit time spans one selected overflow interval, or two on timer 1 without doubling
  assign use_t2  = tx_timer2_sel || rx_timer2_sel;
  assign ovf_sel = use_t2 ? timer2_ovf : timer1_ovf;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ovf_cnt_q    <= '0;
      ovf_period_q <= '0;
    end else if (ovf_sel) begin
      ovf_period_q <= ovf_cnt_q + 1'b1;
      ovf_cnt_q    <= '0;
    end else if (ovf_cnt_q != '1) begin
      ovf_cnt_q <= ovf_cnt_q + 1'b1;
    end
  end

  always_comb begin
    case (mode)
      serial_port_pkg::MODE_SHIFT:  bit_period = serial_port_pkg::DIV_SHIFT;
      serial_port_pkg::MODE_FIXED9: bit_period = baud_double_sel ?
        serial_port_pkg::DIV_FIXED_FAST : serial_port_pkg::DIV_FIXED_SLOW;
      default: begin
        if (use_t2 || baud_double_sel) begin
          bit_period = ovf_period_q;
        end else begin
          bit_period = {ovf_period_q[PW-2:0], 1'b0};
        end
        // no overflow seen yet: keep the timers moving
        if (bit_period == '0) begin
          bit_period = serial_port_pkg::PERIOD_MIN;
        end
      end
    endcase
  end
  assign half = bit_period >> 1;

  // register file
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        serial_port_pkg::ADDR_CONFIG: rd_data <= cfg_q;
        serial_port_pkg::ADDR_DATA:   rd_data <= rx_hold_q;
        default:                      rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_q <= serial_port_pkg::CONFIG_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_q <= reg_req.wdata;
      end
      if (tx_set) begin
        cfg_q.tx_done_flag <= 1'b1;
      end
      if (rx_set) begin
        cfg_q.rx_done_flag <= 1'b1;
      end
      if (rx_set && nine) begin
        cfg_q.rx_ninth_bit <= rx_word[8];
      end
    end
  end

  // transmitter; writes while busy are dropped
  assign tx_go = wr_dat && tx_state_q == serial_port_pkg::TX_IDLE &&
                 (mode != serial_port_pkg::MODE_SHIFT ||
                  (!cfg_q.tx_done_flag &&
                   rx_state_q == serial_port_pkg::RX_IDLE));
  assign tx_set = tx_state_q == serial_port_pkg::TX_SHIFT &&
                  tx_cnt_q == '0 && tx_bits_q == 4'h1;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tx_state_q <= serial_port_pkg::TX_IDLE;
      tx_shift_q <= '1;
      tx_bits_q  <= '0;
      tx_cnt_q   <= '0;
    end else if (tx_go) begin
      tx_state_q <= serial_port_pkg::TX_SHIFT;
      tx_cnt_q   <= bit_period - 1'b1;
      case (mode)
        serial_port_pkg::MODE_SHIFT: begin
          tx_shift_q <= {3'h7, reg_req.wdata};
          tx_bits_q  <= serial_port_pkg::BITS_SHIFT;
        end
        serial_port_pkg::MODE_ASYNC8: begin
          tx_shift_q <= {2'h3, reg_req.wdata, 1'b0};
          tx_bits_q  <= serial_port_pkg::BITS_ASYNC8;
        end
        default: begin
          tx_shift_q <= {1'b1, cfg_q.tx_ninth_bit, reg_req.wdata, 1'b0};
          tx_bits_q  <= serial_port_pkg::BITS_NINE;
        end
      endcase
    end else if (tx_state_q == serial_port_pkg::TX_SHIFT) begin
      if (tx_cnt_q == '0) begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_bits_q  <= tx_bits_q - 1'b1;
        tx_cnt_q   <= bit_period - 1'b1;
        if (tx_bits_q == 4'h1) begin
          tx_state_q <= serial_port_pkg::TX_IDLE;
        end
      end else begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end
    end
  end

  // receiver
  assign rx_go0 = mode == serial_port_pkg::MODE_SHIFT &&
                  rx_state_q == serial_port_pkg::RX_IDLE &&
                  cfg_q.rx_enable && !cfg_q.rx_done_flag &&
                  tx_state_q == serial_port_pkg::TX_IDLE && !tx_go;
  assign rx_go_async = mode != serial_port_pkg::MODE_SHIFT &&
                       rx_state_q == serial_port_pkg::RX_IDLE &&
                       cfg_q.rx_enable && rx_prev && !rx_s;
  assign rx_sample = rx_state_q == serial_port_pkg::RX_DATA &&
                     (mode == serial_port_pkg::MODE_SHIFT ?
                      rx_cnt_q == half - 1'b1 : rx_cnt_q == '0);
  assign rx_last = mode == serial_port_pkg::MODE_SHIFT ?
                   rx_bits_q == 4'h0 : rx_bits_q == 4'h1;
  assign rx_finish = rx_state_q == serial_port_pkg::RX_DATA &&
                     rx_cnt_q == '0 && rx_last;
  assign rx_word = {rx_s, rx_shift_q[9:1]};

  always_comb begin
    case (mode)
      serial_port_pkg::MODE_SHIFT:  rx_byte = rx_shift_q[9:2];
      serial_port_pkg::MODE_ASYNC8: rx_byte = rx_word[8:1];
      default:                      rx_byte = rx_word[7:0];
    endcase
  end

  // a set rx_done_flag blocks the next load, even once the byte is read; that byte is lost
  assign rx_accept = !cfg_q.rx_done_flag &&
                     !(nine && cfg_q.multiproc_enable && !rx_word[8]);
  assign rx_set = rx_finish && rx_accept;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_state_q <= serial_port_pkg::RX_IDLE;
      rx_cnt_q   <= '0;
      rx_bits_q  <= '0;
      rx_shift_q <= '0;
    end else begin
      case (rx_state_q)
        serial_port_pkg::RX_IDLE: begin
          if (rx_go0) begin
            rx_state_q <= serial_port_pkg::RX_DATA;
            rx_cnt_q   <= bit_period - 1'b1;
            rx_bits_q  <= serial_port_pkg::BITS_SHIFT;
          end else if (rx_go_async) begin
            rx_state_q <= serial_port_pkg::RX_START;
            rx_cnt_q   <= half;
          end
        end
        serial_port_pkg::RX_START: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else if (!rx_s) begin
            rx_state_q <= serial_port_pkg::RX_DATA;
            rx_cnt_q   <= bit_period - 1'b1;
            rx_bits_q  <= nine ? serial_port_pkg::SAMPLES_9 :
                                 serial_port_pkg::SAMPLES_8;
          end else begin
            rx_state_q <= serial_port_pkg::RX_IDLE;
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_shift_q <= rx_word;
            rx_bits_q  <= rx_bits_q - 1'b1;
          end
          if (rx_cnt_q == '0) begin
            rx_cnt_q <= bit_period - 1'b1;
            if (rx_last) begin
              rx_state_q <= serial_port_pkg::RX_IDLE;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end
        end
        default: rx_state_q <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_hold_q <= serial_port_pkg::DATA_RESET;
    end else if (rx_set) begin
      rx_hold_q <= rx_byte;
    end
  end

  // shift clock: high first half of each bit, so data moves on the rise
  assign shift_clk = (tx_state_q == serial_port_pkg::TX_SHIFT ||
                      rx_state_q == serial_port_pkg::RX_DATA) &&
                     (tx_state_q == serial_port_pkg::TX_SHIFT ?
                      tx_cnt_q >= half : rx_cnt_q >= half);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      serial_out_pin <= 1'b1;
      serial_in_oe   <= 1'b0;
      wake_pulse     <= 1'b0;
    end else begin
      if (mode == serial_port_pkg::MODE_SHIFT) begin
        serial_out_pin <= shift_clk;
        serial_in_oe   <= tx_state_q == serial_port_pkg::TX_SHIFT &&
                          !tx_shift_q[0];
      end else begin
        serial_out_pin <= tx_state_q == serial_port_pkg::TX_SHIFT ?
                          tx_shift_q[0] : 1'b1;
        serial_in_oe   <= 1'b0;
      end
      wake_pulse <= slow_clock_mode && cfg_q.rx_enable &&
                    (rx_s != rx_prev);
    end
  end

  // open drain: only ever pulls low
  assign serial_in_o = 1'b0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_read_hold;
    reg_req.rd && reg_req.addr == serial_port_pkg::ADDR_DATA
      |=> rd_data == $past(rx_hold_q);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("data read did not return holding register");

  property p_shift_gate;
    wr_dat && mode == serial_port_pkg::MODE_SHIFT && cfg_q.tx_done_flag
      && !wr_cfg |=> tx_state_q == $past(tx_state_q);
  endproperty
  a_shift_gate: assert property (p_shift_gate)
    else $error("shift send started with done flag set");

  property p_fixed_rate;
    mode == serial_port_pkg::MODE_FIXED9 |->
      bit_period == (baud_double_sel ? 17'h00020 : 17'h00040);
  endproperty
  a_fixed_rate: assert property (p_fixed_rate)
    else $error("fixed rate period wrong");

  property p_shift_clk_rate;
    mode == serial_port_pkg::MODE_SHIFT ##0 $rose(serial_out_pin)
      ##1 (mode == serial_port_pkg::MODE_SHIFT)[*5]
      |=> !serial_out_pin;
  endproperty
  a_shift_clk_rate: assert property (p_shift_clk_rate)
    else $error("shift clock high phase not six cycles");

  property p_tx_sticky;
    cfg_q.tx_done_flag && !wr_cfg |=> cfg_q.tx_done_flag;
  endproperty
  a_tx_sticky: assert property (p_tx_sticky)
    else $error("transmit done dropped without write");

  property p_tx_done_set;
    tx_set |=> cfg_q.tx_done_flag && tx_state_q == serial_port_pkg::TX_IDLE;
  endproperty
  a_tx_done_set: assert property (p_tx_done_set)
    else $error("transmit done not set at frame end");

  property p_rx_sticky;
    cfg_q.rx_done_flag && !wr_cfg |=> cfg_q.rx_done_flag;
  endproperty
  a_rx_sticky: assert property (p_rx_sticky)
    else $error("receive done dropped without write");

  property p_mp_filter;
    rx_finish && nine && cfg_q.multiproc_enable && !rx_word[8]
      && !cfg_q.rx_done_flag && !wr_cfg |=> !cfg_q.rx_done_flag;
  endproperty
  a_mp_filter: assert property (p_mp_filter)
    else $error("data byte passed address filter");

  property p_ninth_store;
    rx_set && nine |=> cfg_q.rx_ninth_bit == $past(rx_word[8]);
  endproperty
  a_ninth_store: assert property (p_ninth_store)
    else $error("received ninth bit not stored");

  property p_ninth_send;
    tx_go && nine |=> tx_shift_q[9] == $past(cfg_q.tx_ninth_bit);
  endproperty
  a_ninth_send: assert property (p_ninth_send)
    else $error("ninth bit not taken from config");

  property p_no_wake;
    !cfg_q.rx_enable |=> !wake_pulse;
  endproperty
  a_no_wake: assert property (p_no_wake)
    else $error("wake raised with receive disabled");

endmodule

// >>> remote_serial_peer.sv
// far-end serial port: decodes device frames, sends async and shift frames
// assumes the bench sets period and frame length before each transfer
`timescale 1ns/1ps

module remote_serial_peer (
  input  wire logic       clk,     // cpu clock
  input  wire logic [7:0] period,  // cycles per bit
  input  wire logic [3:0] nbits,   // frame bits incl start and stop
  input  wire logic       listen,  // decode device frames
  input  wire logic       tx_line, // device serial output
  output logic            rx_line  // 0 pulls low, 1 releases
);
  logic [9:0] got;
  int         frames;

  initial begin
    rx_line = 1'b1;
    got = '0;
    frames = 0;
  end

  // start seen at mid-bit, then one sample per bit centre
  initial begin
    forever begin
      @(negedge tx_line iff listen);
      got = '0;
      repeat (period / 2) @(posedge clk);
      for (int i = 0; i < nbits - 1; i++) begin
        repeat (period) @(posedge clk);
        got[i] = tx_line;
      end
      frames++;
    end
  end

  // frame word: bit 0 start, then data lsb first, ninth, stop
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      repeat (period) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask

  // shift mode: next bit goes out as the device clock rises
  task automatic shift_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_line);
      rx_line <= b[i];
    end
    @(negedge tx_line);
    rx_line <= 1'b1;
  endtask
endmodule

// >>> four_mode_serial_port_tb.sv
// self-checking bench for the four-mode serial port
// assumes remote_serial_peer on the line, pull-up on the rx wire
`timescale 1ns/1ps

module four_mode_serial_port_tb;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] data;
    logic       dbl;
    logic       t2tx;
    logic       t2rx;
    logic [7:0] per;
    logic [3:0] nb;
  } tx_row_type;

  logic                       ref_clk, resetn, sin_o;
  serial_port_pkg::reg_req_type reg_req;
  logic [7:0]                 rd_data, per, d;
  logic                       baud_double_sel, tx_timer2_sel;
  logic                       rx_timer2_sel, timer1_ovf, timer2_ovf;
  logic                       slow_clock_mode, wake_pulse, serial_out_pin;
  logic                       oe, peer_rx, listen, shift_on;
  logic [3:0]                 nb;
  logic [7:0]                 shift_got = 8'h00;
  wire logic                  line_w = peer_rx & (oe ? sin_o : 1'b1);
  int                         cycles = 0, rises = 0, wakes = 0;
  int                         fail_count, checks, w0;
  tx_row_type                 rows [6];

  four_mode_serial_port dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
    .rd_data(rd_data), .baud_double_sel(baud_double_sel),
    .tx_timer2_sel(tx_timer2_sel), .rx_timer2_sel(rx_timer2_sel),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .slow_clock_mode(slow_clock_mode), .wake_pulse(wake_pulse),
    .serial_out_pin(serial_out_pin), .serial_in_i(line_w),
    .serial_in_o(sin_o), .serial_in_oe(oe));

  remote_serial_peer peer_u (
    .clk(ref_clk), .period(per), .nbits(nb), .listen(listen),
    .tx_line(serial_out_pin), .rx_line(peer_rx));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // overflow pulses every 8 and 10 cycles; a hang ends the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    timer1_ovf <= (cycles % 8 == 0);
    timer2_ovf <= (cycles % 10 == 0);
    if (wake_pulse === 1'b1) wakes <= wakes + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // shift mode data is valid on the falling shift clock
  always @(negedge serial_out_pin) begin
    if (shift_on) shift_got <= {line_w, shift_got[7:1]};
  end
  always @(posedge serial_out_pin) if (shift_on) rises <= rises + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    @(posedge ref_clk);
    v = rd_data;
  endtask

  task automatic wait_frame;
    int f0;
    int n;
    f0 = peer_u.frames;
    n = 0;
    while (peer_u.frames == f0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check(16'(n < 2000), 16'h0001);
  endtask

  initial begin
    reg_req = '0;
    {baud_double_sel, tx_timer2_sel, rx_timer2_sel} = 3'b000;
    {slow_clock_mode, listen, shift_on} = 3'h0;
    fail_count = 0;
    checks = 0;
    per = 8'h10;
    nb = 4'hA;
    resetn = 1'b0;
    rows = '{'{8'h40, 8'h96, 1'b0, 1'b0, 1'b0, 8'h10, 4'hA},
             '{8'hC8, 8'h3C, 1'b1, 1'b0, 1'b0, 8'h08, 4'hB},
             '{8'hC0, 8'hA1, 1'b0, 1'b1, 1'b0, 8'h0A, 4'hB},
             '{8'h40, 8'h5A, 1'b1, 1'b0, 1'b1, 8'h0A, 4'hA},
             '{8'h88, 8'hC3, 1'b0, 1'b0, 1'b0, 8'h40, 4'hB},
             '{8'h80, 8'h81, 1'b1, 1'b0, 1'b0, 8'h20, 4'hB}};
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, serial_port_pkg::CONFIG_RESET);
    rd_reg(serial_port_pkg::ADDR_DATA, d);
    check(d, serial_port_pkg::DATA_RESET);
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'h5C);
    wr_reg(8'h9A, 8'hFF);
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, 8'h5C);
    rd_reg(8'h97, d);
    check(d, 8'h00);
    // every async mode and rate source: frame bits, ninth bit, done flag
    foreach (rows[i]) begin
      baud_double_sel <= rows[i].dbl;
      tx_timer2_sel <= rows[i].t2tx;
      rx_timer2_sel <= rows[i].t2rx;
      per <= rows[i].per;
      nb <= rows[i].nb;
      wr_reg(serial_port_pkg::ADDR_CONFIG, rows[i].cfg);
      listen <= 1'b1;
      repeat (40) @(posedge ref_clk);
      wr_reg(serial_port_pkg::ADDR_DATA, rows[i].data);
      wait_frame();
      check(peer_u.got, (rows[i].nb == 4'hB) ?
            {6'h01, rows[i].cfg[3], rows[i].data} :
            {8'h01, rows[i].data});
      repeat (rows[i].per + 4) @(posedge ref_clk);
      rd_reg(serial_port_pkg::ADDR_CONFIG, d);
      check(d, rows[i].cfg | 8'h02);
    end
    // receive in fixed fast mode, then address filtering
    listen <= 1'b0;
    per <= 8'h20;
    baud_double_sel <= 1'b1;
    {tx_timer2_sel, rx_timer2_sel} <= 2'b00;
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'h90);
    peer_u.send({2'b11, 8'hA5, 1'b0}, 11);
    repeat (8) @(posedge ref_clk);
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, 8'h95);
    rd_reg(serial_port_pkg::ADDR_DATA, d);
    check(d, 8'hA5);
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'hB0);
    peer_u.send({2'b10, 8'h3C, 1'b0}, 11);
    repeat (8) @(posedge ref_clk);
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, 8'hB0);
    peer_u.send({2'b11, 8'h5A, 1'b0}, 11);
    repeat (8) @(posedge ref_clk);
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, 8'hB5);
    rd_reg(serial_port_pkg::ADDR_DATA, d);
    check(d, 8'h5A);
    // shift mode: eight clocks, lsb first, second write refused
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'h00);
    shift_on <= 1'b1;
    wr_reg(serial_port_pkg::ADDR_DATA, 8'hB4);
    repeat (110) @(posedge ref_clk);
    wr_reg(serial_port_pkg::ADDR_DATA, 8'h77);
    repeat (110) @(posedge ref_clk);
    check(16'(rises), 16'h0008);
    check(shift_got, 8'hB4);
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, 8'h02);
    // shift mode receive: starts on enable with done clear
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'h10);
    peer_u.shift_byte(8'h6C);
    repeat (12) @(posedge ref_clk);
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, 8'h11);
    rd_reg(serial_port_pkg::ADDR_DATA, d);
    check(d, 8'h6C);
    // wake from slow mode only with receive enabled
    shift_on <= 1'b0;
    per <= 8'h10;
    baud_double_sel <= 1'b0;
    slow_clock_mode <= 1'b1;
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'h50);
    w0 = wakes;
    peer_u.send(11'h000, 1);
    repeat (12) @(posedge ref_clk);
    check(16'(wakes - w0), 16'h0002);
    wr_reg(serial_port_pkg::ADDR_CONFIG, 8'h40);
    repeat (400) @(posedge ref_clk);
    w0 = wakes;
    peer_u.send(11'h000, 1);
    repeat (12) @(posedge ref_clk);
    check(16'(wakes - w0), 16'h0000);
    // reset in mid-run restores the config register default
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_reg(serial_port_pkg::ADDR_CONFIG, d);
    check(d, serial_port_pkg::CONFIG_RESET);
    end_sim();
  end
endmodule
